// ### design/imp_defs.svh
// offsets, field positions, reset values and vector numbers of the interrupt controller
`ifndef IMP_DEFS_SVH
`define IMP_DEFS_SVH
// register byte offsets
`define IMP_LSEL_A_OFS 8'h00
`define IMP_LSEL_B_OFS 8'h04
`define IMP_LSEL_C_OFS 8'h08
`define IMP_LSEL_D_OFS 8'h0c
`define IMP_CTRL_OFS 8'h10
`define IMP_STATE_OFS 8'h14
`define IMP_EVT_STAT_OFS 8'h18
`define IMP_EVT_CLR_OFS 8'h1c
`define IMP_EVT_EN_OFS 8'h20
// reset values
`define IMP_LSEL_RST 8'h00
`define IMP_CTRL_RST 1'b0
`define IMP_EVT_EN_RST 3'h0
// event bit positions
`define IMP_EVT_TAKEN 0
`define IMP_EVT_NMI 1
`define IMP_EVT_RSVD 2
`define IMP_EVT_W 3
// vector numbers
`define IMP_VEC_NMI 7'h07
`define IMP_VEC_EXT2 7'h12
`define IMP_VEC_EXT3 7'h13
`define IMP_VEC_ABRK 7'h1b
`define IMP_VEC_CONV 7'h1c
`define IMP_VEC_CYC0 7'h30
`define IMP_VEC_CYC1 7'h31
`define IMP_VEC_IR 7'h5d
`define IMP_VEC_RSVD_LO 7'h70
`define IMP_NVEC 128
`endif

// ### design/imp_pkg.sv
// shared types of the interrupt controller
package imp_pkg;
  typedef logic [6:0] imp_vec_t;
  typedef logic [23:0] imp_addr_t;
  typedef enum logic {IMP_MODE_PLAIN, IMP_MODE_TWO_BIT} imp_mode_t;
endpackage

// ### design/imp_first_set.sv
// lowest set bit finder over the vector space
`timescale 1ns/1ps
module imp_first_set
  import imp_pkg::*;
(
  input wire logic [127:0] req,
  output logic found,
  output imp_pkg::imp_vec_t idx
);
  // ===========================================
  // scan
  // lower vector number wins among equals
  always_comb begin
    found = 1'b0;
    idx = 7'h00;
    for (int i = 127; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 7'(i);
      end
    end
  end
endmodule // imp_first_set

// ### design/imp_evt_stat.sv
// sticky event status with enable and write-one-to-clear
`timescale 1ns/1ps
`include "imp_defs.svh"
module imp_evt_stat (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`IMP_EVT_W-1:0] evt,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [`IMP_EVT_W-1:0] wdata,
  output logic [`IMP_EVT_W-1:0] stat_r,
  output logic [`IMP_EVT_W-1:0] en_r,
  output logic irq
);
  // ===========================================
  // status
  // a set in the same cycle as its clear survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~(clr_we ? wdata : '0)) | evt;
    end
  end
  // ===========================================
  // enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_r <= `IMP_EVT_EN_RST;
    end else if (en_we) begin
      en_r <= wdata;
    end
  end
  assign irq = |(stat_r & en_r);
endmodule // imp_evt_stat

// ### design/imp_ctrl.sv
// interrupt mask, priority and vectoring controller with wishbone registers
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "imp_defs.svh"
// Operation
// - both bits set: mask all except nmi, break
// - level zero accepted only with disable clear
// - level one accepted unless both bits set
// - select bit one moves sources to level one
// - order: nmi, level one, break, level zero
// - conversion end uses vector 28
// - pulse unit zero: vectors 34-38, one bit
// - cycle timer channels merge onto 48, 49
// - second serial channel uses vectors 88-91
// - two-wire channels use vectors 92, 94, 95
// - infrared sources merge onto vector 93
// - keyboard tx and first edge share vectors
// - host bus uses vectors 106 through 111
// - reserved vectors are never requested
module imp_ctrl
  import imp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [127:0] src_req,
  input wire logic nmi_req,
  input wire logic addr_break_req,
  input wire logic [4:0] cyc0_irqs,
  input wire logic [4:0] cyc1_irqs,
  input wire logic [5:0] infrared_irqs,
  input wire logic [3:0] kbd_tx_done_irqs,
  input wire logic [3:0] kbd_first_edge_irqs,
  input wire logic int_disable,
  input wire logic user_irq_flag,
  input wire logic vec_take,
  output logic vec_valid,
  output imp_pkg::imp_vec_t vec_num_r,
  output imp_pkg::imp_addr_t vec_addr_r
);
  import imp_pkg::*;

  // ===========================================
  // source to level-select bit map
  // returns {valid, register, bit}; register a is 0
  function automatic logic [5:0] lsel_idx(input imp_vec_t v);
    logic [5:0] r;
    r = 6'h00;
    if (v == `IMP_VEC_EXT2 || v == `IMP_VEC_EXT3) r = {1'b1, 2'd0, 3'd5};
    else if (v == 7'd25) r = {1'b1, 2'd0, 3'd1};
    else if (v == 7'd26) r = {1'b1, 2'd0, 3'd0};
    else if (v == `IMP_VEC_CONV) r = {1'b1, 2'd1, 3'd7};
    else if (v == 7'd33) r = {1'b1, 2'd3, 3'd4};
    else if (v >= 7'd34 && v <= 7'd38) r = {1'b1, 2'd3, 3'd3};
    else if (v >= 7'd39 && v <= 7'd42) r = {1'b1, 2'd3, 3'd2};
    else if (v >= 7'd43 && v <= 7'd46) r = {1'b1, 2'd3, 3'd1};
    else if (v == `IMP_VEC_CYC0) r = {1'b1, 2'd1, 3'd6};
    else if (v >= 7'd88 && v <= 7'd91) r = {1'b1, 2'd2, 3'd5};
    else if (v == 7'd92) r = {1'b1, 2'd2, 3'd4};
    else if (v == `IMP_VEC_IR) r = {1'b1, 2'd1, 3'd4};
    else if (v == 7'd94 || v == 7'd95) r = {1'b1, 2'd2, 3'd3};
    else if (v >= 7'd96 && v <= 7'd103) r = {1'b1, 2'd1, 3'd0};
    else if (v == 7'd104 || (v >= 7'd106 && v <= 7'd111)) r = {1'b1, 2'd2, 3'd1};
    return r;
  endfunction

  // sources that exist; everything else, reserved ranges included, is dropped
  function automatic logic vec_exists(input imp_vec_t v);
    logic [5:0] li;
    li = lsel_idx(v);
    return li[5] || v == `IMP_VEC_CYC1 || v == `IMP_VEC_NMI || v == `IMP_VEC_ABRK;
  endfunction

  // ===========================================
  // registers
  logic [7:0] lsel_a_r, lsel_b_r, lsel_c_r, lsel_d_r;
  imp_mode_t mode_r;
  logic [31:0] lsel_flat;
  logic [`IMP_EVT_W-1:0] evt_stat, evt_en, evt;
  logic bus_req, wr_en, rd_hit;
  logic [31:0] rd_nxt;
  logic [127:0] pend_r, raw_req, exist_mask, lvl1_mask, lvl1_ok, lvl0_ok;
  logic lvl1_found, lvl0_found, sel_found;
  imp_vec_t lvl1_idx, lvl0_idx, sel_idx;
  logic mask_lvl0, mask_lvl1;

  assign lsel_flat = {lsel_d_r, lsel_c_r, lsel_b_r, lsel_a_r};
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

  // ===========================================
  // wishbone slave: answers one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lsel_a_r <= `IMP_LSEL_RST;
      lsel_b_r <= `IMP_LSEL_RST;
      lsel_c_r <= `IMP_LSEL_RST;
      lsel_d_r <= `IMP_LSEL_RST;
      mode_r <= IMP_MODE_PLAIN;
    end else if (wr_en) begin
      if (wb_adr_i == `IMP_LSEL_A_OFS) begin
        lsel_a_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `IMP_LSEL_B_OFS) begin
        lsel_b_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `IMP_LSEL_C_OFS) begin
        lsel_c_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `IMP_LSEL_D_OFS) begin
        lsel_d_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `IMP_CTRL_OFS) begin
        mode_r <= imp_mode_t'(wb_dat_i[0]);
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == `IMP_LSEL_A_OFS) begin
      rd_nxt = {24'h00_0000, lsel_a_r};
    end else if (wb_adr_i == `IMP_LSEL_B_OFS) begin
      rd_nxt = {24'h00_0000, lsel_b_r};
    end else if (wb_adr_i == `IMP_LSEL_C_OFS) begin
      rd_nxt = {24'h00_0000, lsel_c_r};
    end else if (wb_adr_i == `IMP_LSEL_D_OFS) begin
      rd_nxt = {24'h00_0000, lsel_d_r};
    end else if (wb_adr_i == `IMP_CTRL_OFS) begin
      rd_nxt = {31'h0000_0000, mode_r};
    end else if (wb_adr_i == `IMP_STATE_OFS) begin
      rd_nxt = {16'h0000, vec_valid, vec_num_r, 6'h00, pend_r[`IMP_VEC_ABRK], pend_r[`IMP_VEC_NMI]};
    end else if (wb_adr_i == `IMP_EVT_STAT_OFS) begin
      rd_nxt = {29'h0000_0000, evt_stat};
    end else if (wb_adr_i == `IMP_EVT_EN_OFS) begin
      rd_nxt = {29'h0000_0000, evt_en};
    end
  end

  // read data only changes on an accepted read; unmapped reads return zero
  assign rd_hit = bus_req & ~wb_we_i;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ===========================================
  // request collection
  always_comb begin
    raw_req = src_req;
    raw_req[`IMP_VEC_NMI] = nmi_req;
    raw_req[`IMP_VEC_ABRK] = addr_break_req;
    raw_req[`IMP_VEC_CYC0] = src_req[`IMP_VEC_CYC0] | (|cyc0_irqs);
    raw_req[`IMP_VEC_CYC1] = src_req[`IMP_VEC_CYC1] | (|cyc1_irqs);
    raw_req[`IMP_VEC_IR] = src_req[`IMP_VEC_IR] | (|infrared_irqs);
    raw_req[99] = src_req[99] | kbd_tx_done_irqs[0] | kbd_first_edge_irqs[0];
    raw_req[100] = src_req[100] | kbd_tx_done_irqs[1] | kbd_first_edge_irqs[1];
    raw_req[101] = src_req[101] | kbd_tx_done_irqs[2] | kbd_first_edge_irqs[2];
    raw_req[103] = src_req[103] | kbd_tx_done_irqs[3] | kbd_first_edge_irqs[3];
  end

  always_comb begin
    logic [5:0] li;
    li = 6'h00;
    exist_mask = '0;
    lvl1_mask = '0;
    for (int v = 0; v < `IMP_NVEC; v++) begin
      li = lsel_idx(7'(v));
      exist_mask[v] = vec_exists(7'(v));
      lvl1_mask[v] = li[5] && lsel_flat[li[4:0]];
    end
    lvl1_mask[`IMP_VEC_NMI] = 1'b0;
    lvl1_mask[`IMP_VEC_ABRK] = 1'b0;
  end

  // pending requests are held until the core takes them; a new request beats the take
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      for (int v = 0; v < `IMP_NVEC; v++) begin
        if (raw_req[v] && exist_mask[v]) begin
          pend_r[v] <= 1'b1;
        end else if (vec_take && vec_valid && vec_num_r == 7'(v)) begin
          pend_r[v] <= 1'b0;
        end
      end
    end
  end

  // ===========================================
  // masking and priority
  // plain mode ignores the user bit and the level select
  assign mask_lvl0 = int_disable;
  assign mask_lvl1 = (mode_r == IMP_MODE_TWO_BIT) ? (int_disable & user_irq_flag) : int_disable;

  always_comb begin
    lvl1_ok = '0;
    lvl0_ok = '0;
    if (mode_r == IMP_MODE_TWO_BIT && !mask_lvl1) begin
      lvl1_ok = pend_r & lvl1_mask;
    end
    if (!mask_lvl0) begin
      lvl0_ok = pend_r & ~((mode_r == IMP_MODE_TWO_BIT) ? lvl1_mask : '0);
    end
    lvl0_ok[`IMP_VEC_NMI] = 1'b0;
    lvl0_ok[`IMP_VEC_ABRK] = 1'b0;
  end

  imp_first_set u_lvl1 (
    .req(lvl1_ok),
    .found(lvl1_found),
    .idx(lvl1_idx)
  );

  imp_first_set u_lvl0 (
    .req(lvl0_ok),
    .found(lvl0_found),
    .idx(lvl0_idx)
  );

  always_comb begin
    sel_found = 1'b1;
    if (pend_r[`IMP_VEC_NMI]) begin
      sel_idx = `IMP_VEC_NMI;
    end else if (lvl1_found) begin
      sel_idx = lvl1_idx;
    end else if (pend_r[`IMP_VEC_ABRK]) begin
      sel_idx = `IMP_VEC_ABRK;
    end else begin
      sel_idx = lvl0_idx;
      sel_found = lvl0_found;
    end
  end

  // vector registered; a take clears the offer for one cycle so a stale vector is not taken twice
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vec_valid <= 1'b0;
      vec_num_r <= 7'h00;
      vec_addr_r <= 24'h00_0000;
    end else begin
      vec_valid <= sel_found & ~vec_take;
      vec_num_r <= sel_idx;
      vec_addr_r <= {15'h0000, sel_idx, 2'b00};
    end
  end

  // ===========================================
  // events and interrupt output
  always_comb begin
    evt = '0;
    evt[`IMP_EVT_TAKEN] = vec_take & vec_valid;
    evt[`IMP_EVT_NMI] = vec_take & vec_valid & (vec_num_r == `IMP_VEC_NMI);
    evt[`IMP_EVT_RSVD] = |(raw_req & ~exist_mask);
  end

  imp_evt_stat u_evt (
    .ref_clk(ref_clk),
    .rst(rst),
    .evt(evt),
    .clr_we(wr_en && wb_adr_i == `IMP_EVT_CLR_OFS),
    .en_we(wr_en && wb_adr_i == `IMP_EVT_EN_OFS),
    .wdata(wb_dat_i[`IMP_EVT_W-1:0]),
    .stat_r(evt_stat),
    .en_r(evt_en),
    .irq(irq_o)
  );

  // ===========================================
  // checks
  property p_nmi_first;
    @(posedge ref_clk) disable iff (rst) pend_r[`IMP_VEC_NMI] |=> vec_num_r == `IMP_VEC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi not ranked first");

  property p_lvl0_held;
    @(posedge ref_clk) disable iff (rst)
      vec_valid && $past(int_disable) && vec_num_r != `IMP_VEC_NMI && vec_num_r != `IMP_VEC_ABRK
      |-> mode_r == IMP_MODE_TWO_BIT && lvl1_mask[vec_num_r];
  endproperty
  a_lvl0_held: assert property (p_lvl0_held) else $error("level zero delivered while disabled");

  property p_both_set;
    @(posedge ref_clk) disable iff (rst)
      vec_valid && $past(int_disable & user_irq_flag) |-> vec_num_r == `IMP_VEC_NMI || vec_num_r == `IMP_VEC_ABRK;
  endproperty
  a_both_set: assert property (p_both_set) else $error("maskable vector with both bits set");

  property p_addr_x4;
    @(posedge ref_clk) disable iff (rst) vec_valid |-> vec_addr_r == {15'h0000, vec_num_r, 2'b00};
  endproperty
  a_addr_x4: assert property (p_addr_x4) else $error("vector address mismatch");

  property p_no_rsvd;
    @(posedge ref_clk) disable iff (rst) vec_valid |-> vec_num_r < `IMP_VEC_RSVD_LO && vec_num_r != 7'd105;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved vector offered");

  property p_conv_kept;
    @(posedge ref_clk) disable iff (rst)
      src_req[`IMP_VEC_CONV] ##1 !(vec_take && vec_valid && vec_num_r == `IMP_VEC_CONV) |=> pend_r[`IMP_VEC_CONV];
  endproperty
  a_conv_kept: assert property (p_conv_kept) else $error("conversion end request lost");

  property p_cyc0_merge;
    @(posedge ref_clk) disable iff (rst) |cyc0_irqs |=> pend_r[`IMP_VEC_CYC0];
  endproperty
  a_cyc0_merge: assert property (p_cyc0_merge) else $error("timer request not on vector 48");

  property p_ir_merge;
    @(posedge ref_clk) disable iff (rst) |infrared_irqs |=> pend_r[`IMP_VEC_IR];
  endproperty
  a_ir_merge: assert property (p_ir_merge) else $error("infrared request not on vector 93");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (rst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack held two cycles");
endmodule // imp_ctrl

// ### tb/imp_core_model.sv
// processor core model: shows the mask bits and takes offered vectors
`timescale 1ns/1ps
module imp_core_model
  import imp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_dis,
  input wire logic set_user,
  input wire logic [1:0] delay,
  input wire logic vec_valid,
  input wire imp_pkg::imp_vec_t vec_num_r,
  input wire imp_pkg::imp_addr_t vec_addr_r,
  output logic int_disable,
  output logic user_irq_flag,
  output logic vec_take,
  output logic got,
  output imp_pkg::imp_vec_t got_num,
  output imp_pkg::imp_addr_t got_addr
);
  logic [1:0] wait_r;
  // ==========================================
  // mask bits, shown every cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_disable <= 1'b0;
      user_irq_flag <= 1'b0;
    end else begin
      int_disable <= set_dis;
      user_irq_flag <= set_user;
    end
  end
  // ==========================================
  // take after a chosen wait; a slow core tests that the offer stands
  always_ff @(posedge ref_clk) begin
    vec_take <= 1'b0;
    got <= 1'b0;
    if (rst || !vec_valid || vec_take) begin
      wait_r <= 2'h0;
    end else if (wait_r == delay) begin
      vec_take <= 1'b1;
      got <= 1'b1;
      got_num <= vec_num_r;
      got_addr <= vec_addr_r;
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule // imp_core_model

// ### tb/tb_top.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "imp_defs.svh"
module tb_top;
  import imp_pkg::*;
  logic ref_clk, rst, cyc, stb, we, ack, irq, nmi, brk, dis, usr, take, vvalid, got, set_dis, set_user;
  logic [7:0] adr;
  logic [3:0] sel, kt, kf;
  logic [31:0] wdat, rdat, rd;
  int seed;
  logic [127:0] src;
  logic [4:0] cyc0, cyc1;
  logic [5:0] ir;
  logic [1:0] delay;
  imp_vec_t vnum, got_num;
  imp_addr_t vaddr, got_addr;
  int n_errors, n_checks, r;
  int tbl[23] = '{28, 34, 35, 36, 37, 38, 88, 89, 90, 91, 92, 94, 95, 96, 97, 98, 102, 106, 107, 108, 109, 110, 111};
  imp_ctrl imp_ctrl_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .src_req(src), .nmi_req(nmi),
    .addr_break_req(brk), .cyc0_irqs(cyc0), .cyc1_irqs(cyc1), .infrared_irqs(ir), .kbd_tx_done_irqs(kt),
    .kbd_first_edge_irqs(kf), .int_disable(dis), .user_irq_flag(usr), .vec_take(take), .vec_valid(vvalid),
    .vec_num_r(vnum), .vec_addr_r(vaddr));
  imp_core_model imp_core_model_i (.ref_clk(ref_clk), .rst(rst), .set_dis(set_dis), .set_user(set_user),
    .delay(delay), .vec_valid(vvalid), .vec_num_r(vnum), .vec_addr_r(vaddr), .int_disable(dis),
    .user_irq_flag(usr), .vec_take(take), .got(got), .got_num(got_num), .got_addr(got_addr));
  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] addr_of(input logic [6:0] v);
    return {15'h0000, v, 2'h0};
  endfunction
  function automatic logic [6:0] kbd_vec(input int k);
    return (k == 3) ? 7'h67 : 7'(99 + k);
  endfunction
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // classic single cycle; ack is sampled at the edge, never assumed
  // only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic fire(input logic [127:0] v, input logic n, input logic b);
    @(posedge ref_clk);
    src <= v;
    nmi <= n;
    brk <= b;
    delay <= 2'($random(seed));
    @(posedge ref_clk);
    src <= '0;
    nmi <= 1'b0;
    brk <= 1'b0;
  endtask
  task automatic expect_vec(input logic [6:0] v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (got !== 1'b1 && n < 40);
    check({31'h0, got}, 32'h1);
    check({25'h0, got_num}, {25'h0, v});
    check({8'h0, got_addr}, {8'h0, addr_of(v)});
  endtask
  task automatic expect_idle(input int c);
    repeat (c) begin
      @(posedge ref_clk);
      check({31'h0, vvalid}, 32'h0);
    end
  endtask
  task automatic grp(input int g, input int k, input logic [6:0] v);
    @(posedge ref_clk);
    case (g)
      0: cyc0 <= 5'h01 << k;
      1: cyc1 <= 5'h01 << k;
      2: ir <= 6'h01 << k;
      3: kt <= 4'h1 << k;
      default: kf <= 4'h1 << k;
    endcase
    @(posedge ref_clk);
    {cyc0, cyc1, ir, kt, kf} <= '0;
    expect_vec(v);
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
  // ==========================================
  // main sequence
  initial begin
    {cyc, stb, we, nmi, brk, set_dis, set_user, delay, adr, wdat, src, cyc0, cyc1, ir, kt, kf} = '0;
    sel = 4'h1;
    seed = 32'h3921bea4;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, `IMP_LSEL_A_OFS + 8'(4 * i), 8'h00);
      check(rd, 32'h0);
      r = $random(seed);
      wb(1'b1, `IMP_LSEL_A_OFS + 8'(4 * i), r[7:0]);
      wb(1'b0, `IMP_LSEL_A_OFS + 8'(4 * i), 8'h00);
      check(rd, {24'h0, r[7:0]});
      wb(1'b1, `IMP_LSEL_A_OFS + 8'(4 * i), (i == 0) ? 8'h20 : 8'h00);
    end
    wb(1'b0, 8'h40, 8'h00);
    check(rd, 32'h0);
    foreach (tbl[i]) begin
      fire(128'h1 << tbl[i], 1'b0, 1'b0);
      expect_vec(7'(tbl[i]));
    end
    for (int k = 0; k < 6; k++) begin
      if (k < 5) begin
        grp(0, k, 7'h30);
        grp(1, k, 7'h31);
      end
      grp(2, k, 7'h5d);
      if (k < 4) begin
        grp(3, k, kbd_vec(k));
        grp(4, k, kbd_vec(k));
      end
    end
    // reserved requests are dropped and flagged as an event
    wb(1'b1, `IMP_EVT_CLR_OFS, 8'h07);
    for (int i = 0; i < 4; i++) begin
      fire(128'h1 << (112 + ($unsigned($random(seed)) % 16)), 1'b0, 1'b0);
      expect_idle(6);
    end
    // no vector was taken since the clear, so only the reserved bit stands
    wb(1'b0, `IMP_EVT_STAT_OFS, 8'h00);
    check(rd, 32'h4);
    wb(1'b1, `IMP_EVT_EN_OFS, 8'h04);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, `IMP_EVT_EN_OFS, 8'h00);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, `IMP_EVT_EN_OFS, 8'h04);
    wb(1'b1, `IMP_EVT_CLR_OFS, 8'h07);
    check({31'h0, irq}, 32'h0);
    // two-bit mask mode: held requests survive until unmasked
    wb(1'b1, `IMP_CTRL_OFS, 8'h01);
    set_dis <= 1'b1;
    set_user <= 1'b1;
    fire((128'h1 << 28) | (128'h1 << 18), 1'b0, 1'b0);
    expect_idle(6);
    fire('0, 1'b1, 1'b1);
    expect_vec(`IMP_VEC_NMI);
    expect_vec(`IMP_VEC_ABRK);
    set_user <= 1'b0;
    expect_vec(`IMP_VEC_EXT2);
    expect_idle(5);
    set_dis <= 1'b0;
    expect_vec(`IMP_VEC_CONV);
    // priority in both modes; level one only exists in mode two
    for (int m = 1; m >= 0; m--) begin
      wb(1'b1, `IMP_CTRL_OFS, 8'(m));
      fire((128'h1 << 28) | (128'h1 << 19) | (128'h1 << 92) | (128'h1 << 89), 1'b1, 1'b1);
      expect_vec(`IMP_VEC_NMI);
      expect_vec(m ? `IMP_VEC_EXT3 : `IMP_VEC_ABRK);
      expect_vec(m ? `IMP_VEC_ABRK : `IMP_VEC_EXT3);
      expect_vec(`IMP_VEC_CONV);
      expect_vec(7'h59);
      expect_vec(7'h5c);
    end
    // takes since the last clear, non-maskable ones among them; nothing reserved
    wb(1'b0, `IMP_EVT_STAT_OFS, 8'h00);
    check(rd, 32'h3);
    finish_test();
  end
endmodule // tb_top
